// ===== rtl/psram_host.sv
// Purpose: Host controller driving a refresh-hiding SRAM-style memory port.
// Assumes: Memory pins sampled and driven on clk; data bus is three signals.
// Notes: One request at a time; each access is a full read or write cycle.
// Contract
// - Byte write uses one lane select
// - Address held through write recovery
// - Break write bursts after fifty writes
// - Wake uses the power-up sequence
// - Wait 200us deselected, then two reads
// - Dummy reads start with select low, full cycle
// - Sleep pin high through power-up
// - Alternative: 500us wait without dummy reads
// - Reads never linger; every read full cycle
// - Writes pause write enable every window; code pauses after 33 writes, 132 cycles against a 100-cycle window
module psram_host
  import psram_host_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned EXTRA_CYCLES = EXTRA_CYC,
  parameter bit USE_DUMMY_READS = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // User request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_lanes,
  // User answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // Power control
  input wire logic sleep_req,
  output logic awake,
  // Memory pins
  output logic chip_select_bar,
  output logic write_enable_bar,
  output logic output_enable_bar,
  output logic upper_lane_select_bar,
  output logic lower_lane_select_bar,
  output logic sleep_pin_bar,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);

  localparam int unsigned TW = 24;  // Timer width covers the 500 us wait

  initial begin
    if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << TW)) $error("bad POWERUP_CYCLES");
    if (EXTRA_CYCLES < 1 || EXTRA_CYCLES >= (1 << TW)) $error("bad EXTRA_CYCLES");
  end

  typedef enum logic [8:0] {
    S_PWRUP = 9'h001,  // Deselected start-up wait
    S_EXTRA = 9'h002,  // Extra wait instead of dummy reads
    S_DUMMY = 9'h004,  // Dummy read in progress
    S_DGAP = 9'h008,   // Select high between dummy reads
    S_IDLE = 9'h010,   // Ready for requests
    S_READ = 9'h020,   // Read cycle
    S_WRITE = 9'h040,  // Write pulse
    S_RECOV = 9'h080,  // Write end, address held
    S_SLEEP = 9'h100   // Deep power-down
  } state_t;

  // Width-fitted counts for the timer
  function automatic logic [TW-1:0] cyc(input int unsigned n);
    cyc = TW'(n - 1);
  endfunction

  state_t st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;      // Address on the pins
  logic [DATA_W-1:0] wdat_q, wdat_d;      // Write data on the pins
  logic [1:0] lanes_q, lanes_d;           // Lane selects, active high
  logic [DATA_W-1:0] rdat_q, rdat_d;      // Captured read data
  logic rsp_q, rsp_d;                     // Read answer pulse
  logic [5:0] run_q, run_d;               // Writes since last break
  logic [1:0] dummy_q, dummy_d;           // Dummy reads done
  logic [1:0] rdy_q, rdy_d;               // Idle cycles in a row, for window breaks
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;
  logic armed_q, armed_d;                 // Start-up wait loaded since reset
  logic need_break;                       // A write must wait for a pause
  logic break_done;                       // Write enable high long enough

  // Shared wait timer for every timed phase
  cycle_timer #(.W(TW)) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .load(tmr_load),
    .value(tmr_val),
    .done(tmr_done)
  );

  // Sequencer next-state logic
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    lanes_d = lanes_q;
    rdat_d = rdat_q;
    rsp_d = 1'b0;
    run_d = run_q;
    dummy_d = dummy_q;
    rdy_d = rdy_q;
    armed_d = armed_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (st_q)
      S_PWRUP: begin
        // Select high for the start-up wait, sleep pin high. The timer rests
        // at zero after reset, so the wait is loaded here on first entry.
        if (!armed_q) begin
          armed_d = 1'b1;
          tmr_load = 1'b1;
          tmr_val = cyc(POWERUP_CYCLES);
        end else if (tmr_done) begin
          tmr_load = 1'b1;
          if (USE_DUMMY_READS) begin
            st_d = S_DUMMY;
            tmr_val = cyc(READ_CYC);
          end else begin
            st_d = S_EXTRA;
            tmr_val = cyc(EXTRA_CYCLES);
          end
        end
      end
      S_EXTRA: begin
        if (tmr_done) st_d = S_IDLE;
      end
      S_DUMMY: begin
        // Each dummy read lasts a full read cycle
        if (tmr_done) begin
          dummy_d = dummy_q + 2'd1;
          if (dummy_q == 2'(DUMMY_READS - 1)) begin
            st_d = S_IDLE;
          end else begin
            st_d = S_DGAP;
          end
        end
      end
      S_DGAP: begin
        // Select goes high so the next dummy read starts on its fall
        tmr_load = 1'b1;
        tmr_val = cyc(READ_CYC);
        st_d = S_DUMMY;
      end
      S_IDLE: begin
        rdy_d = (rdy_q == 2'd3) ? rdy_q : rdy_q + 2'd1;
        // A served pause with write enable high starts a fresh write run
        if (break_done) run_d = '0;
        if (sleep_req) begin
          st_d = S_SLEEP;
          tmr_load = 1'b1;
          tmr_val = cyc(SUSPEND_CYC);
        end else if (req_valid && req_ready) begin
          // Same test as ready, so an owed write break really holds the write
          // Taken at once: no wait from the memory exists
          addr_d = req_addr;
          wdat_d = req_wdata;
          lanes_d = req_lanes;
          tmr_load = 1'b1;
          rdy_d = 2'd0;
          if (req_write && req_lanes == 2'b00) begin
            // No lane picked: skip the pulse, a write must select a lane
            st_d = S_RECOV;
          end else if (req_write) begin
            st_d = S_WRITE;
            tmr_val = cyc(WRITE_CYC);
          end else begin
            st_d = S_READ;
            run_d = '0; // A read cycle breaks a write run
            tmr_val = cyc(READ_CYC);
          end
        end
      end
      S_READ: begin
        if (tmr_done) begin
          rdat_d = dq_in;
          rsp_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      S_WRITE: begin
        if (tmr_done) begin
          st_d = S_RECOV;
          run_d = run_q + 6'd1;
        end
      end
      S_RECOV: begin
        // Address still held one cycle after write enable rises; data drive already off
        st_d = S_IDLE;
      end
      S_SLEEP: begin
        // Leaving power-down repeats the whole start-up sequence
        if (!sleep_req && tmr_done) begin
          st_d = S_PWRUP;
          dummy_d = '0;
          run_d = '0;
          tmr_load = 1'b1;
          tmr_val = cyc(POWERUP_CYCLES);
        end
      end
      default: st_d = S_PWRUP;
    endcase
  end

  // Sequencer registers; reset starts the power-up wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_PWRUP;
      addr_q <= '0;
      wdat_q <= '0;
      lanes_q <= 2'h0;
      rdat_q <= '0;
      rsp_q <= 1'b0;
      run_q <= '0;
      dummy_q <= '0;
      rdy_q <= 2'h0;
      armed_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      lanes_q <= lanes_d;
      rdat_q <= rdat_d;
      rsp_q <= rsp_d;
      run_q <= run_d;
      dummy_q <= dummy_d;
      rdy_q <= rdy_d;
      armed_q <= armed_d;
    end
  end

  // A write run must pause at the burst limit or after WINDOW_CYC / (WRITE_CYC + 1) writes,
  // a count that allows three cycles a write where each takes four; a pause keeps write enable high for a read cycle.
  assign need_break = (run_q >= 6'(MAX_WRITE_RUN))
                    || (run_q >= 6'(WINDOW_CYC / (WRITE_CYC + 1)));
  assign break_done = (rdy_q >= 2'(READ_CYC));

  // Ready only in idle, and a write waits while a break is owed
  assign req_ready = (st_q == S_IDLE) && !sleep_req
                   && !(req_write && need_break && !break_done);

  // Pin drive from state
  always_comb begin
    chip_select_bar = !(st_q inside {S_DUMMY, S_READ, S_WRITE, S_RECOV, S_IDLE});
    write_enable_bar = (st_q != S_WRITE);
    output_enable_bar = !(st_q inside {S_READ, S_DUMMY});
    upper_lane_select_bar = !((st_q == S_DUMMY) || lanes_q[1]);
    lower_lane_select_bar = !((st_q == S_DUMMY) || lanes_q[0]);
    sleep_pin_bar = (st_q != S_SLEEP);
  end

  assign mem_addr = addr_q;
  assign dq_out = wdat_q;
  assign dq_oe = (st_q == S_WRITE);
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdat_q;
  assign awake = (st_q inside {S_IDLE, S_READ, S_WRITE, S_RECOV});

  // Checks
  sequence write_pulse_s;
    (st_q == S_WRITE) [*2];
  endsequence

  chk_write_overlap: assert property (@(posedge clk) disable iff (!rst_n)
    !write_enable_bar |-> !chip_select_bar && dq_oe)
    else $error("write enable low without select and data");
  chk_lane_select: assert property (@(posedge clk) disable iff (!rst_n)
    !write_enable_bar |-> !(upper_lane_select_bar && lower_lane_select_bar))
    else $error("write with no lane selected");
  chk_write_end: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(write_enable_bar) |-> !chip_select_bar)
    else $error("write not ended by write enable");
  chk_addr_hold: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(write_enable_bar) |-> $stable(mem_addr))
    else $error("address moved at write end");
  chk_write_len: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(write_enable_bar) |-> write_pulse_s ##1 write_enable_bar)
    else $error("write pulse length wrong");
  chk_run_limit: assert property (@(posedge clk) disable iff (!rst_n)
    run_q <= 6'(MAX_WRITE_RUN))
    else $error("write run over limit");
  chk_sleep_enter: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sleep_pin_bar) |-> chip_select_bar [*8])
    else $error("select active in power-down");
  chk_data_release: assert property (@(posedge clk) disable iff (!rst_n)
    (!sleep_pin_bar || !output_enable_bar) |-> !dq_oe)
    else $error("host drives data while memory may");
  chk_powerup_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q inside {S_PWRUP, S_EXTRA, S_DUMMY, S_DGAP}) |-> sleep_pin_bar)
    else $error("sleep pin low in power-up");
  chk_read_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(output_enable_bar) |-> !output_enable_bar [*2])
    else $error("read shorter than read cycle");

endmodule // psram_host

// ===== rtl/psram_host_pkg.sv
// Purpose: Shared constants for the refreshed-cell SRAM port controller.
// Assumes: 25 MHz system clock (40 ns period).
// Notes: Times kept in their own unit; cycle counts derived from them.
package psram_host_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_PS = 40000;

  // Pin widths
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;

  // Documented times
  localparam int unsigned READ_CYCLE_MIN_PS = 70000;   // Minimum read cycle
  localparam int unsigned WRITE_PULSE_MIN_PS = 50000;  // Minimum write pulse
  localparam int unsigned WRITE_RECOVERY_PS = 0;       // Address hold after write end
  localparam int unsigned SUSPEND_NS = 500;            // Power-down entry suspend
  localparam int unsigned POWERUP_WAIT_US = 200;       // Select high after supply
  localparam int unsigned POWERUP_EXTRA_US = 300;      // Further wait, no dummy reads
  localparam int unsigned REFRESH_WINDOW_NS = 4000;    // Longest unbroken activity

  // Derived cycle counts (least times round up, longest round down)
  localparam int unsigned READ_CYC =
    (READ_CYCLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WRITE_CYC =
    (WRITE_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RECOV_CYC =
    (WRITE_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
  localparam int unsigned SUSPEND_CYC =
    (SUSPEND_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned POWERUP_CYC =
    (POWERUP_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned EXTRA_CYC =
    (POWERUP_EXTRA_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WINDOW_CYC = (REFRESH_WINDOW_NS * 1000) / CLK_PERIOD_PS;

  // Burst and start-up limits
  localparam int unsigned MAX_WRITE_RUN = 50;  // Writes before a forced break
  localparam int unsigned DUMMY_READS = 2;     // Reads that finish power-up

endpackage

// ===== rtl/cycle_timer.sv
// Purpose: Loadable down-counter that flags when a wait has elapsed.
// Assumes: Load and count are synchronous to clk.
// Notes: done is high while the count stands at zero.
module cycle_timer
  import psram_host_pkg::*;
#(
  parameter int unsigned W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [W-1:0] value,
  // Status
  output logic done
);

  logic [W-1:0] cnt_q;  // Cycles still to wait
  logic [W-1:0] cnt_d;

  initial begin
    if (W < 2) $error("cycle_timer: W too small");
  end

  // Next count: load wins, else count down to zero and rest
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Register the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done = (cnt_q == '0);

endmodule // cycle_timer

// ===== bench/sram_cell_model.sv
// Purpose: Behavioural model of the refresh-hiding SRAM-style memory.
// Assumes: Host data is valid on host_dq while host_oe is high.
// Notes: No clock; acts on pin levels. Released lanes show a toggling pattern.
module sram_cell_model
  import psram_host_pkg::*;
#(
  parameter realtime PU_NS = 200000.0,
  parameter realtime ALT_NS = 500000.0
) (
  // Control pins, no hold-off output exists
  input wire logic chip_select_bar,
  input wire logic write_enable_bar,
  input wire logic output_enable_bar,
  input wire logic upper_lane_select_bar,
  input wire logic lower_lane_select_bar,
  input wire logic sleep_pin_bar,
  // Address and data
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] host_dq,
  input wire logic host_oe,
  output logic [DATA_W-1:0] dq,
  // Normal mode reached
  output logic up
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]]; // Sparse cells
  logic [DATA_W-1:0] ww; // Word being merged
  logic [DATA_W-1:0] rw; // Word read out
  logic ph = 1'b0; // Toggles so a released lane never keeps a stale value
  logic dpd = 1'b0; // Deep power-down
  int reads = 0; // Start-up reads seen
  realtime hi_since = 0.0; // Select or sleep pin last rose
  initial up = 1'b0;
  initial forever #20 ph = ~ph;
  // Start-up wait is timed from the last rise of select
  always @(posedge chip_select_bar) hi_since = $realtime;
  // Start-up: wait then two reads, or the long wait alone
  always @(negedge chip_select_bar) begin
    if (!up && sleep_pin_bar && !dpd) begin
      if ($realtime - hi_since >= ALT_NS) begin
        up = 1'b1;
      end else if (reads > 0 || $realtime - hi_since >= PU_NS) begin
        reads = reads + 1;
        up = (reads >= DUMMY_READS);
      end
    end
  end
  // Cells are lost only if the pin stays low through the suspend period
  always @(negedge sleep_pin_bar) begin
    #(SUSPEND_NS);
    if (!sleep_pin_bar) begin
      dpd = 1'b1;
      up = 1'b0;
      reads = 0;
      mem.delete();
    end
  end
  // Wake restarts the start-up sequence
  always @(posedge sleep_pin_bar) begin
    dpd = 1'b0;
    hi_since = $realtime;
  end
  // Write during the select and write-enable overlap, lanes picked by selects
  always @(chip_select_bar or write_enable_bar or upper_lane_select_bar or
      lower_lane_select_bar or mem_addr or host_dq or host_oe) begin
    if (up && sleep_pin_bar && !chip_select_bar && !write_enable_bar && host_oe) begin
      ww = mem.exists(mem_addr) ? mem[mem_addr] : 16'hFFFF;
      if (!upper_lane_select_bar) ww[15:8] = host_dq[15:8];
      if (!lower_lane_select_bar) ww[7:0] = host_dq[7:0];
      mem[mem_addr] = ww;
    end
  end
  // Read path answers at once; lanes float unless selected in a read
  always @(chip_select_bar or output_enable_bar or write_enable_bar or mem_addr or
      upper_lane_select_bar or lower_lane_select_bar or sleep_pin_bar or dpd or ph or up) begin
    rw = (up && mem.exists(mem_addr)) ? mem[mem_addr] : {DATA_W{ph}} ^ 16'h3C96;
    dq = {DATA_W{ph}} ^ 16'hA53C;
    if (!chip_select_bar && sleep_pin_bar && !dpd && write_enable_bar && !output_enable_bar) begin
      if (!upper_lane_select_bar) dq[15:8] = rw[15:8];
      if (!lower_lane_select_bar) dq[7:0] = rw[7:0];
    end
  end
endmodule // sram_cell_model

// ===== bench/tb_refreshed_cell_sram_port.sv
// Purpose: Self-checking bench for the SRAM-style port controller.
// Assumes: Start-up waits shortened to ten cycles each.
// Notes: A pin monitor checks write runs, address hold and read length.
module tb_refreshed_cell_sram_port
  import psram_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PU = 10; // Shortened start-up wait
  logic clk, rst_n, req_valid, req_ready, req_write, rsp_valid, sleep_req, awake, up;
  logic chip_select_bar, write_enable_bar, output_enable_bar, dq_oe, we_p, oe_p;
  logic upper_lane_select_bar, lower_lane_select_bar, sleep_pin_bar;
  logic [ADDR_W-1:0] req_addr, mem_addr, addr_p;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, dq_in, dq_out, dev_dq;
  logic [1:0] req_lanes;
  int err_count = 0;
  int cmp_count = 0;
  int we_hi = 0; // Cycles write enable stood high
  int run = 0; // Writes since the last break
  int burst = 0; // Cycles since the burst began
  int oe_lo = 0; // Cycles output enable stood low
  // Wire level of the shared data lanes
  assign dq_in = dq_oe ? dq_out : dev_dq;
  psram_host #(.POWERUP_CYCLES(PU), .EXTRA_CYCLES(PU), .USE_DUMMY_READS(1'b1)) uut (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sleep_req(sleep_req), .awake(awake),
    .chip_select_bar(chip_select_bar), .write_enable_bar(write_enable_bar),
    .output_enable_bar(output_enable_bar), .upper_lane_select_bar(upper_lane_select_bar),
    .lower_lane_select_bar(lower_lane_select_bar), .sleep_pin_bar(sleep_pin_bar),
    .mem_addr(mem_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  sram_cell_model #(.PU_NS(PU * 40.0), .ALT_NS(2 * PU * 40.0)) dev (
    .chip_select_bar(chip_select_bar), .write_enable_bar(write_enable_bar),
    .output_enable_bar(output_enable_bar), .upper_lane_select_bar(upper_lane_select_bar),
    .lower_lane_select_bar(lower_lane_select_bar), .sleep_pin_bar(sleep_pin_bar),
    .mem_addr(mem_addr), .host_dq(dq_out), .host_oe(dq_oe), .dq(dev_dq), .up(up));
  // Second controller in the long-wait start-up mode, on a memory of its own
  logic awake_alt, up_alt, cs_bar_alt, we_bar_alt, oe_bar_alt, oe_alt;
  logic ub_bar_alt, lb_bar_alt, sleep_bar_alt;
  logic [ADDR_W-1:0] addr_alt;
  logic [DATA_W-1:0] dq_in_alt, dq_out_alt, dev_dq_alt;
  assign dq_in_alt = oe_alt ? dq_out_alt : dev_dq_alt;
  psram_host #(.POWERUP_CYCLES(PU), .EXTRA_CYCLES(PU), .USE_DUMMY_READS(1'b0)) uut_alt (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
    .rsp_valid(), .rsp_rdata(), .sleep_req(sleep_req), .awake(awake_alt),
    .chip_select_bar(cs_bar_alt), .write_enable_bar(we_bar_alt),
    .output_enable_bar(oe_bar_alt), .upper_lane_select_bar(ub_bar_alt),
    .lower_lane_select_bar(lb_bar_alt), .sleep_pin_bar(sleep_bar_alt),
    .mem_addr(addr_alt), .dq_in(dq_in_alt), .dq_out(dq_out_alt), .dq_oe(oe_alt));
  sram_cell_model #(.PU_NS(PU * 40.0), .ALT_NS(2 * PU * 40.0)) dev_alt (
    .chip_select_bar(cs_bar_alt), .write_enable_bar(we_bar_alt),
    .output_enable_bar(oe_bar_alt), .upper_lane_select_bar(ub_bar_alt),
    .lower_lane_select_bar(lb_bar_alt), .sleep_pin_bar(sleep_bar_alt),
    .mem_addr(addr_alt), .host_dq(dq_out_alt), .host_oe(oe_alt), .dq(dev_dq_alt),
    .up(up_alt));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    check_val(what, {31'h0, exp}, {31'h0, got});
  endtask
  // Pin monitor sees values of the cycle just ended
  always @(posedge clk) begin
    if (rst_n) begin
      burst++;
      if (!write_enable_bar && we_p) begin
        if (we_hi >= READ_CYC) begin
          run = 0;
          burst = 0;
        end
        run++;
        check_flag("write run", 1'b1, run <= MAX_WRITE_RUN);
        check_flag("write window", 1'b1, burst + WRITE_CYC <= WINDOW_CYC);
      end
      if (write_enable_bar && !we_p) check_val("held addr", {12'h0, addr_p}, {12'h0, mem_addr});
      if (output_enable_bar && !oe_p) check_flag("read length", 1'b1, oe_lo >= READ_CYC);
      if (!output_enable_bar) check_flag("lane contention", 1'b0, dq_oe);
      we_hi = write_enable_bar ? we_hi + 1 : 0;
      oe_lo = output_enable_bar ? 0 : oe_lo + 1;
    end
    we_p = write_enable_bar;
    oe_p = output_enable_bar;
    addr_p = mem_addr;
  end
  // Present a request right after an edge and hold it until taken
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [1:0] ln);
    int n;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lanes <= ln;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    check_flag("request taken", 1'b1, req_ready);
    @(posedge clk);
  endtask
  task automatic idle();
    req_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    int n;
    req(1'b0, a, 16'h0000, 2'b11);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 8);
    check_flag("read answer", 1'b1, rsp_valid);
    check_val("read data", {16'h0, exp}, {16'h0, rsp_rdata});
    @(posedge clk);
  endtask
  task automatic wait_awake();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (awake !== 1'b1 && n < 200);
    check_flag("awake", 1'b1, awake);
    check_flag("memory ready", 1'b1, up);
    @(posedge clk);
  endtask
  task automatic t_word();
    req(1'b1, 20'h12345, 16'hBEEF, 2'b11);
    req(1'b1, 20'h12346, 16'h1234, 2'b11);
    idle();
    rd(20'h12345, 16'hBEEF);
    rd(20'h12346, 16'h1234);
  endtask
  task automatic t_lanes();
    req(1'b1, 20'h00100, 16'hA1B2, 2'b11);
    req(1'b1, 20'h00100, 16'hFFC3, 2'b01);
    req(1'b1, 20'h00100, 16'hD4FF, 2'b10);
    req(1'b1, 20'h00100, 16'h0000, 2'b00);
    idle();
    rd(20'h00100, 16'hD4C3);
  endtask
  task automatic t_burst();
    for (int i = 0; i < 60; i++) req(1'b1, 20'h00200 + 20'(i), 16'h5A00 ^ 16'(i), 2'b11);
    idle();
    rd(20'h00200, 16'h5A00);
    rd(20'h0023B, 16'h5A3B);
  endtask
  task automatic t_sleep();
    sleep_req <= 1'b1;
    repeat (20) @(posedge clk);
    check_flag("sleep pin", 1'b0, sleep_pin_bar);
    check_flag("ready asleep", 1'b0, req_ready);
    check_flag("memory down", 1'b0, up);
    sleep_req <= 1'b0;
    @(posedge clk);
    wait_awake();
    req(1'b1, 20'h00300, 16'h7E81, 2'b11);
    idle();
    rd(20'h00300, 16'h7E81);
  endtask
  // Long-wait start-up: select stays high, no dummy reads, then normal mode
  task automatic t_alt_start();
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (awake_alt !== 1'b1 && n < 200);
    check_flag("long wait awake", 1'b1, awake_alt);
    check_flag("long wait memory ready", 1'b1, up_alt);
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    req_lanes = 2'b00;
    sleep_req = 1'b0;
    repeat (3) @(posedge clk);
    check_flag("select in reset", 1'b1, chip_select_bar);
    check_flag("sleep pin in reset", 1'b1, sleep_pin_bar);
    check_flag("data drive in reset", 1'b0, dq_oe);
    check_flag("ready in reset", 1'b0, req_ready);
    check_flag("long wait select in reset", 1'b1, cs_bar_alt);
    rst_n <= 1'b1;
    @(posedge clk);
    wait_awake();
    t_alt_start();
    t_word();
    t_lanes();
    t_burst();
    t_sleep();
    final_report();
  end
  // Run should take well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule // tb_refreshed_cell_sram_port
